/* rmc_pkg.sv */
// Shared constants and types for the radio modem configuration bank
package rmc_pkg;
  // Register addresses
  localparam logic [15:0] RMC_ADDR_CODING = 16'hdf0f;
  localparam logic [15:0] RMC_ADDR_MANT = 16'hdf10;
  localparam logic [15:0] RMC_ADDR_DEV = 16'hdf11;
  // Field positions
  localparam int RMC_FEC_BIT = 7;
  localparam int RMC_PRE_LSB = 4;
  localparam int RMC_PRE_MSB = 6;
  localparam int RMC_SPE_LSB = 0;
  localparam int RMC_SPE_MSB = 1;
  localparam int RMC_DEVE_LSB = 4;
  localparam int RMC_DEVE_MSB = 6;
  localparam int RMC_DEVM_LSB = 0;
  localparam int RMC_DEVM_MSB = 2;
  // Writable bit masks; other bits are unused and read as zero
  localparam logic [7:0] RMC_CODING_MASK = 8'hf3;
  localparam logic [7:0] RMC_MANT_MASK = 8'hff;
  localparam logic [7:0] RMC_DEV_MASK = 8'h77;
  // Values after reset
  localparam logic [7:0] RMC_CODING_RST = 8'h22;
  localparam logic [7:0] RMC_MANT_RST = 8'hf8;
  localparam logic [7:0] RMC_DEV_RST = 8'h47;
  localparam logic [4:0] RMC_PRE_BYTES_RST = 5'h04;
  // Implied leading ones of the mantissas
  localparam logic [11:0] RMC_SPC_LEAD = 12'h100;
  localparam logic [10:0] RMC_DEV_LEAD = 11'h008;
  // Preamble byte counts per code 0..7
  localparam logic [4:0] RMC_PRE_TAB [8] = '{5'h02, 5'h03, 5'h04, 5'h06,
                                             5'h08, 5'h0c, 5'h10, 5'h18};
  // Modulation formats
  typedef enum logic [1:0] {
    RMC_MOD_2FSK,
    RMC_MOD_GFSK,
    RMC_MOD_ASK,
    RMC_MOD_MSK
  } rmc_mod_t;
endpackage

/* rmc_cfg_if.sv */
// Carrier between the register bank and its value calculator
`timescale 1ns/100ps
interface rmc_cfg_if;
  import rmc_pkg::*;
  logic [7:0] coding_q;
  logic [7:0] mant_q;
  logic [7:0] dev_q;
  logic [25:0] base_freq;
  logic [7:0] channel_index;
  rmc_mod_t mod;
  logic tx_mode;
  logic tx_bit;
  logic [11:0] channel_index_step;
  logic [25:0] synth_freq;
  logic signed [11:0] dev_offset;
  logic [4:0] preamble_bytes;
  modport regs (output coding_q, mant_q, dev_q, base_freq, channel_index,
                output mod, tx_mode, tx_bit,
                input channel_index_step, synth_freq, dev_offset, preamble_bytes);
  modport calc (input coding_q, mant_q, dev_q, base_freq, channel_index,
                input mod, tx_mode, tx_bit,
                output channel_index_step, synth_freq, dev_offset, preamble_bytes);
endinterface

/* rmc_calc.sv */
// Derived modem values: channel step, synthesizer word, deviation
`timescale 1ns/100ps
module rmc_calc
  import rmc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Configuration in, results out
  rmc_cfg_if.calc cfg
);
  logic [1:0] sp_exp;
  logic [2:0] dv_exp;
  logic [11:0] step_d;
  logic [10:0] dev_mag;
  logic [25:0] freq_d;

  // Mantissa/exponent expansion
  assign sp_exp = cfg.coding_q[RMC_SPE_MSB:RMC_SPE_LSB];
  assign dv_exp = cfg.dev_q[RMC_DEVE_MSB:RMC_DEVE_LSB];
  assign step_d = (RMC_SPC_LEAD + {4'h0, cfg.mant_q}) << sp_exp;
  assign dev_mag = (RMC_DEV_LEAD +
                    {8'h00, cfg.dev_q[RMC_DEVM_MSB:RMC_DEVM_LSB]})
                   << dv_exp;
  assign freq_d = cfg.base_freq +
                  26'(step_d) * 26'(cfg.channel_index);

  // Channel step and synthesizer word
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg.channel_index_step <= 12'h000;
      cfg.synth_freq <= 26'h0000000;
    end else begin
      cfg.channel_index_step <= step_d;
      cfg.synth_freq <= freq_d;
    end
  end

  // Signed deviation per modulation and direction
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg.dev_offset <= 12'sh000;
    end else begin
      case (cfg.mod)
        RMC_MOD_2FSK, RMC_MOD_GFSK: begin
          if (cfg.tx_mode && !cfg.tx_bit) begin
            cfg.dev_offset <= -$signed({1'b0, dev_mag});
          end else begin
            cfg.dev_offset <= $signed({1'b0, dev_mag});
          end
        end
        RMC_MOD_MSK: begin
          cfg.dev_offset <= cfg.tx_mode ? $signed({1'b0, dev_mag})
                                        : 12'sh000;
        end
        default: begin
          cfg.dev_offset <= 12'sh000;
        end
      endcase
    end
  end

  // Preamble byte count lookup
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg.preamble_bytes <= RMC_PRE_BYTES_RST;
    end else begin
      cfg.preamble_bytes <=
        RMC_PRE_TAB[cfg.coding_q[RMC_PRE_MSB:RMC_PRE_LSB]];
    end
  end

  // Checks on the derived values
  property p_step_formula;
    @(posedge sys_clk_i) disable iff (rst_i)
    !rst_i |=> cfg.channel_index_step ==
      12'((12'h100 + {4'h0, $past(cfg.mant_q)}) << $past(sp_exp));
  endproperty
  a_step_formula: assert property (p_step_formula)
    else $error("channel step mismatch");

  property p_freq_formula;
    @(posedge sys_clk_i) disable iff (rst_i)
    !rst_i |=> cfg.synth_freq == 26'($past(cfg.base_freq) +
      26'($past(step_d)) * 26'($past(cfg.channel_index)));
  endproperty
  a_freq_formula: assert property (p_freq_formula)
    else $error("synthesizer word mismatch");

  property p_dev_sign;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!rst_i && cfg.tx_mode && cfg.mod == RMC_MOD_2FSK && !cfg.tx_bit) |=>
      cfg.dev_offset < 0 && cfg.dev_offset == -$signed({1'b0, $past(dev_mag)});
  endproperty
  a_dev_sign: assert property (p_dev_sign)
    else $error("zero bit must give negative deviation");

  property p_dev_ask;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg.mod == RMC_MOD_ASK ||
     (cfg.mod == RMC_MOD_MSK && !cfg.tx_mode)) |=> cfg.dev_offset == 0;
  endproperty
  a_dev_ask: assert property (p_dev_ask)
    else $error("deviation must be inert here");

  property p_preamble;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cfg.coding_q[6:4] == 3'h7) |=> cfg.preamble_bytes == 5'h18;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("code 7 must give 24 preamble bytes");

  c_gfsk_one: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    cfg.tx_mode && cfg.mod == RMC_MOD_GFSK && cfg.tx_bit);
endmodule

/* rmc_regs.sv */
// Radio modem configuration register bank, top level
//
// Notes on behaviour
// - Bit 7 set enables payload error coding with interleaving; resets clear.
// - Bits 6:4 pick 2,3,4,6,8,12,16,24 preamble bytes; reset code 010.
// - Bits 1:0 hold channel step exponent, reset 10.
// - Step is (256+mantissa) shifted by exponent; mantissa resets to f8.
// - Synthesizer word is base plus step times channel index.
// - FSK transmit deviates (8+m)<<e; zero bit negative, one positive.
// - Deviation inert for ASK, and for MSK while receiving.
`timescale 1ns/100ps
module rmc_regs
  import rmc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Modem context
  input wire logic [25:0] base_freq_i,
  input wire logic [7:0] channel_index_i,
  input wire rmc_mod_t mod_i,
  input wire logic tx_mode_i,
  input wire logic tx_bit_i,
  // Configuration results
  output logic err_coding_enable_o,
  output logic [4:0] preamble_bytes_o,
  output logic [1:0] channel_index_step_exponent_o,
  output logic [7:0] channel_index_step_mantissa_o,
  output logic [11:0] channel_index_step_o,
  output logic [25:0] synth_freq_o,
  output logic signed [11:0] dev_offset_o
);
  rmc_cfg_if cfg ();
  logic [7:0] coding_q;
  logic [7:0] mant_q;
  logic [7:0] dev_q;
  logic [7:0] rdata_d;

  // Coding and preamble register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      coding_q <= RMC_CODING_RST;
    end else if (wr_i && addr_i == RMC_ADDR_CODING) begin
      coding_q <= wdata_i & RMC_CODING_MASK;
    end
  end

  // Channel step mantissa register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mant_q <= RMC_MANT_RST;
    end else if (wr_i && addr_i == RMC_ADDR_MANT) begin
      mant_q <= wdata_i & RMC_MANT_MASK;
    end
  end

  // Deviation register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_q <= RMC_DEV_RST;
    end else if (wr_i && addr_i == RMC_ADDR_DEV) begin
      dev_q <= wdata_i & RMC_DEV_MASK;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      case (addr_i)
        RMC_ADDR_CODING: rdata_d = coding_q;
        RMC_ADDR_MANT: rdata_d = mant_q;
        RMC_ADDR_DEV: rdata_d = dev_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // Carrier to the calculator
  assign cfg.coding_q = coding_q;
  assign cfg.mant_q = mant_q;
  assign cfg.dev_q = dev_q;
  assign cfg.base_freq = base_freq_i;
  assign cfg.channel_index = channel_index_i;
  assign cfg.mod = mod_i;
  assign cfg.tx_mode = tx_mode_i;
  assign cfg.tx_bit = tx_bit_i;

  rmc_calc u_calc (
    .sys_clk_i (sys_clk_i),
    .rst_i (rst_i),
    .cfg (cfg.calc)
  );

  // Field outputs straight from the registers, derived ones from the calculator
  assign err_coding_enable_o = coding_q[RMC_FEC_BIT];
  assign channel_index_step_exponent_o = coding_q[RMC_SPE_MSB:RMC_SPE_LSB];
  assign channel_index_step_mantissa_o = mant_q;
  assign preamble_bytes_o = cfg.preamble_bytes;
  assign channel_index_step_o = cfg.channel_index_step;
  assign synth_freq_o = cfg.synth_freq;
  assign dev_offset_o = cfg.dev_offset;

  // Checks on the register bank
  property p_fec_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_i && addr_i == 16'hdf0f) |=> err_coding_enable_o == $past(wdata_i[7]);
  endproperty
  a_fec_write: assert property (p_fec_write)
    else $error("error coding enable did not follow write");

  property p_unused_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && addr_i == 16'hdf0f) |=> rdata_o[3:2] == 2'b00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused coding bits read nonzero");

  property p_dev_unused;
    @(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && addr_i == 16'hdf11) |=> rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0;
  endproperty
  a_dev_unused: assert property (p_dev_unused)
    else $error("unused deviation bits read nonzero");

  property p_read_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && addr_i == 16'hdf10 && !wr_i) |=> rdata_o == $past(mant_q)
      ##1 (rdata_o == 8'h00 || $past(rd_i));
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("mantissa read data wrong or held too long");

  property p_exp_stable;
    @(posedge sys_clk_i) disable iff (rst_i)
    !(wr_i && addr_i == 16'hdf0f) |=> $stable(channel_index_step_exponent_o);
  endproperty
  a_exp_stable: assert property (p_exp_stable)
    else $error("exponent changed without a write");

  // Preamble code follows a write to the coding register
  property p_pre_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_i && addr_i == RMC_ADDR_CODING) |=>
      coding_q[RMC_PRE_MSB:RMC_PRE_LSB] == $past(wdata_i[6:4]);
  endproperty
  a_pre_write: assert property (p_pre_write)
    else $error("preamble code did not follow write");

  // Exponent follows a write to the coding register
  property p_exp_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_i && addr_i == RMC_ADDR_CODING) |=>
      channel_index_step_exponent_o == $past(wdata_i[1:0]);
  endproperty
  a_exp_write: assert property (p_exp_write)
    else $error("exponent did not follow write");

  // Mantissa takes all eight written bits
  property p_mant_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_i && addr_i == RMC_ADDR_MANT) |=>
      channel_index_step_mantissa_o == $past(wdata_i);
  endproperty
  a_mant_write: assert property (p_mant_write)
    else $error("mantissa did not follow write");

  // Deviation write drops bits 7 and 3
  property p_dev_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_i && addr_i == RMC_ADDR_DEV) |=>
      dev_q == ($past(wdata_i) & 8'h77);
  endproperty
  a_dev_write: assert property (p_dev_write)
    else $error("deviation write kept unused bits");

  // Writes elsewhere leave every register alone
  property p_unmapped_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_i && addr_i != RMC_ADDR_CODING && addr_i != RMC_ADDR_MANT &&
     addr_i != RMC_ADDR_DEV) |=>
      $stable(coding_q) && $stable(mant_q) && $stable(dev_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write changed a register");

  // Reads elsewhere answer zero
  property p_unmapped_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && addr_i != RMC_ADDR_CODING && addr_i != RMC_ADDR_MANT &&
     addr_i != RMC_ADDR_DEV) |=> rdata_o == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned data");

  // Registers hold their reset values once reset falls
  property p_reset_values;
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> coding_q == RMC_CODING_RST &&
      mant_q == RMC_MANT_RST && dev_q == RMC_DEV_RST;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("registers not at reset values after reset");

  c_fec_on: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    err_coding_enable_o);
  c_read_dev: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_i && addr_i == RMC_ADDR_DEV);
  c_step_max: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    channel_index_step_exponent_o == 2'h3 && mant_q == 8'hff);
endmodule

/* test_rmc_regs.sv */
// Self-checking testbench for the radio modem configuration bank
`timescale 1ns/100ps
module test_rmc_regs;
  import rmc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [25:0] base_freq_i = 26'h0000000;
  logic [7:0] channel_index_i = 8'h00;
  rmc_mod_t mod_i = RMC_MOD_2FSK;
  logic tx_mode_i = 1'b0;
  logic tx_bit_i = 1'b0;
  logic err_coding_enable_o;
  logic [4:0] preamble_bytes_o;
  logic [1:0] channel_index_step_exponent_o;
  logic [7:0] channel_index_step_mantissa_o;
  logic [11:0] channel_index_step_o;
  logic [25:0] synth_freq_o;
  logic signed [11:0] dev_offset_o;
  int num_errors = 0;
  int compares = 0;
  // Preamble byte counts expected per code
  logic [4:0] pre_exp [8] = '{5'h02, 5'h03, 5'h04, 5'h06,
                              5'h08, 5'h0c, 5'h10, 5'h18};

  rmc_regs i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .base_freq_i(base_freq_i), .channel_index_i(channel_index_i),
    .mod_i(mod_i), .tx_mode_i(tx_mode_i), .tx_bit_i(tx_bit_i),
    .err_coding_enable_o(err_coding_enable_o),
    .preamble_bytes_o(preamble_bytes_o),
    .channel_index_step_exponent_o(channel_index_step_exponent_o),
    .channel_index_step_mantissa_o(channel_index_step_mantissa_o),
    .channel_index_step_o(channel_index_step_o), .synth_freq_o(synth_freq_o),
    .dev_offset_o(dev_offset_o)
  );

  // 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;

  // Compare and count
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe, data checked in the answer cycle
  task automatic rd(logic [15:0] a, logic [7:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", rdata_o, exp);
  endtask

  // Let derived outputs settle
  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  // Reset values of registers and outputs
  task automatic reset_checks();
    rd(RMC_ADDR_CODING, 8'h22);
    rd(RMC_ADDR_MANT, 8'hf8);
    rd(RMC_ADDR_DEV, 8'h47);
    chk("fec", err_coding_enable_o, 0);
    chk("pre", preamble_bytes_o, 4);
    chk("exp", channel_index_step_exponent_o, 2);
    chk("step", channel_index_step_o, 12'h7e0);
  endtask

  // Deviation for one modulation context
  task automatic dev_case(rmc_mod_t m, logic t, logic b, int e);
    @(posedge sys_clk_i);
    mod_i <= m;
    tx_mode_i <= t;
    tx_bit_i <= b;
    settle();
    chk("dev", 32'(dev_offset_o), e);
  endtask

  // Verdict
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    num_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [11:0] st;
    logic [25:0] sf;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    reset_checks();
    // Unused bits dropped, error coding enabled by bit 7
    wr(RMC_ADDR_CODING, 8'hff);
    rd(RMC_ADDR_CODING, 8'hf3);
    chk("fec", err_coding_enable_o, 1);
    wr(RMC_ADDR_DEV, 8'hff);
    rd(RMC_ADDR_DEV, 8'h77);
    // Unmapped write leaves coding and mantissa alone, unmapped read is zero
    wr(16'hdf12, 8'h00);
    rd(16'hdf12, 8'h00);
    rd(RMC_ADDR_CODING, 8'hf3);
    rd(RMC_ADDR_MANT, 8'hf8);
    wr(RMC_ADDR_CODING, 8'h72);
    chk("fec", err_coding_enable_o, 0);
    // Every preamble code
    for (int c = 0; c < 8; c++) begin
      wr(RMC_ADDR_CODING, {1'b0, 3'(c), 4'h0});
      settle();
      chk("pre", preamble_bytes_o, pre_exp[c]);
    end
    // Channel step and synthesizer word, with wrap at 26 bits
    @(posedge sys_clk_i);
    base_freq_i <= 26'h3ffff00;
    channel_index_i <= 8'hff;
    for (int e = 0; e < 4; e++) begin
      for (int k = 0; k < 2; k++) begin
        wr(RMC_ADDR_MANT, k ? 8'hff : 8'h00);
        wr(RMC_ADDR_CODING, {6'h08, 2'(e)});
        settle();
        st = 12'((256 + (k ? 255 : 0)) << e);
        sf = 26'h3ffff00 + 26'(st) * 26'hff;
        chk("exp", channel_index_step_exponent_o, e);
        chk("mant", channel_index_step_mantissa_o, k ? 8'hff : 8'h00);
        chk("step", channel_index_step_o, st);
        chk("synth", synth_freq_o, sf);
      end
    end
    // Deviation in each modulation and direction; magnitude 15 << 7
    dev_case(RMC_MOD_2FSK, 1'b1, 1'b0, -1920);
    dev_case(RMC_MOD_2FSK, 1'b1, 1'b1, 1920);
    dev_case(RMC_MOD_GFSK, 1'b1, 1'b0, -1920);
    dev_case(RMC_MOD_GFSK, 1'b0, 1'b0, 1920);
    dev_case(RMC_MOD_ASK, 1'b1, 1'b1, 0);
    dev_case(RMC_MOD_ASK, 1'b0, 1'b1, 0);
    dev_case(RMC_MOD_MSK, 1'b0, 1'b1, 0);
    dev_case(RMC_MOD_MSK, 1'b1, 1'b0, 1920);
    wr(RMC_ADDR_DEV, 8'h02);
    dev_case(RMC_MOD_2FSK, 1'b1, 1'b1, 10);
    // Second reset in mid-run
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    reset_checks();
    close_out();
  end
endmodule
